// ==== rtl/boot_params.svh ====
// Constants of the EEPROM boot loader: timing, memory offsets and codes.
// Assumes inclusion by the loader module only, by bare name.
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH
`define CLK_HZ      25000000
`define STD_HZ      100000
`define FAST_HZ     400000
`define QTR_STD     (`CLK_HZ / (4 * `STD_HZ))
`define QTR_FAST    (`CLK_HZ / (4 * `FAST_HZ))
`define FREE_NS     4700
`define FREE_CYC    ((`FREE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define TIMEOUT_US  1000
`define TIMEOUT_CYC (`TIMEOUT_US * (`CLK_HZ / 1000000))
`define OFF_START   16'h0000
`define OFF_SPEED   8'h05
`define SPEED_BIT   0
`define OFF_REG_LO  8'h08
`define OFF_REG_HI  8'hDF
`define OFF_CRC     8'hE0
`define CRC_POLY    8'h07
`define CRC_INIT    8'h00
`define RD_BIT      1'b1
`define WR_BIT      1'b0
`define ACK_BIT     1'b0
`define NACK_BIT    1'b1
`define PH_SET      2'h0
`define PH_RISE     2'h1
`define PH_SAMPLE   2'h2
`define PH_FALL     2'h3
`define BIT_LAST    3'h7
`define RETRY_DFLT  5'h01
`define SYNC_RST    4'h3
`endif

// ==== rtl/boot_pkg.sv ====
// Types shared by the boot loader modules.
// Assumes no include path; it uses none of the header's constants.
package boot_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_FREE, ST_START, ST_TX, ST_TXACK, ST_RSTART, ST_RX,
      ST_HOLD, ST_RXACK, ST_STOP, ST_WAITSTOP, ST_DONE, ST_FAIL
   } state_t;
   typedef enum logic [1:0] {TX_ADDR_W, TX_OFF_HI, TX_OFF_LO, TX_ADDR_R} tx_step_t;
   typedef struct packed {
      logic [7:0] off;
      logic [7:0] data;
   } cfg_word_t;
endpackage

// ==== rtl/cfg_stream_if.sv ====
// Valid/ready stream carrying register images between loader modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface cfg_stream_if #(parameter int WIDTH = 16);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/boot_fifo.sv ====
// Synchronous FIFO for register images read from the memory.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ns
module boot_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   cfg_stream_if.snk in_s,
   cfg_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ff;
   logic [AW:0]      rd_ff;
   logic             full;
   logic             empty;
   assign full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   assign empty = (wr_ff == rd_ff);
   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem_ff[rd_ff[AW-1:0]];
   always_ff @(posedge clk_i) begin
      if (in_s.valid && !full) begin
         mem_ff[wr_ff[AW-1:0]] <= in_s.data;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ff <= '0;
      end else if (in_s.valid && !full) begin
         wr_ff <= wr_ff + 1'b1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ff <= '0;
      end else if (out_s.ready && !empty) begin
         rd_ff <= rd_ff + 1'b1;
      end
   end
endmodule

// ==== rtl/boot_loader.sv ====
// Boot-time bus master that reads the register image from a serial memory.
// Assumes open-drain SCL/SDA pins resolved outside and a configuration sink.
`timescale 1ns/1ns
`include "boot_params.svh"
module boot_loader import boot_pkg::*; #(
   parameter int TIMEOUT_CYC = `TIMEOUT_CYC,
   parameter int FIFO_DEPTH  = 16
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       external_reset_low_i,
   input  wire logic       por_done_i,
   input  wire logic       memory_boot_skip_n_i,
   input  wire logic       wide_offset_select_i,
   input  wire logic [6:0] memory_base_slave_address_i,
   input  wire logic [4:0] arbitration_retry_count_i,
   input  wire logic [1:0] pll_lock_lost_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       cfg_ready_i,
   output logic            scl_o,
   output logic            scl_oe_n_o,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   output logic            cfg_wr_o,
   output logic [7:0]      cfg_addr_o,
   output logic [7:0]      cfg_data_o,
   output logic            boot_busy_o,
   output logic            serial_port_enable_o,
   output logic            boot_done_o,
   output logic            boot_load_failed_flag_o,
   output logic [1:0]      pll_unlocked_indicator_o
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic       sda_s;
   logic       scl_s;
   logic       rstn_s;
   logic       por_s;
   logic       sda_prev_ff;
   logic       stop_det;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= `SYNC_RST;
         sync_ff <= `SYNC_RST;
      end else begin
         meta_ff <= {por_done_i, external_reset_low_i, scl_i, sda_i};
         sync_ff <= meta_ff;
      end
   end
   assign sda_s  = sync_ff[0];
   assign scl_s  = sync_ff[1];
   assign rstn_s = sync_ff[2];
   assign por_s  = sync_ff[3];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sda_prev_ff <= 1'b1;
      end else begin
         sda_prev_ff <= sda_s;
      end
   end
   assign stop_det = scl_s && sda_s && !sda_prev_ff;

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   state_t     state_ff;
   tx_step_t   step_ff;
   logic [1:0] ph_ff;
   logic [2:0] bit_ff;
   logic [7:0] sh_ff;
   logic [7:0] off_ff;
   logic [7:0] crc_ff;
   logic       fast_ff;
   logic       bad_ff;
   logic [4:0] retry_ff;
   logic       scl_oe_n_ff;
   logic       sda_oe_n_ff;
   logic [5:0] qtr_ff;
   logic [TW-1:0] tmr_ff;
   logic [7:0] free_ff;
   logic       tick;
   logic       tmo;
   logic       go;
   logic       bit_val;
   logic       reg_byte;
   logic       lost;

   cfg_stream_if #(.WIDTH($bits(cfg_word_t))) push_s ();
   cfg_stream_if #(.WIDTH($bits(cfg_word_t))) pop_s ();

   function automatic logic [7:0] tx_byte(input tx_step_t s, input logic [6:0] sa);
      logic [7:0] b;
      b = {sa, `WR_BIT};
      unique case (s)
         TX_ADDR_W: b = {sa, `WR_BIT};
         TX_OFF_HI: b = 8'(`OFF_START >> 8);
         TX_OFF_LO: b = 8'(`OFF_START & 16'h00FF);
         TX_ADDR_R: b = {sa, `RD_BIT};
      endcase
      return b;
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // ----------------------------------------
   // Bit timing, timer and bus-free counter
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         qtr_ff <= '0;
      end else if (qtr_ff == '0) begin
         qtr_ff <= fast_ff ? 6'(`QTR_FAST - 1) : 6'(`QTR_STD - 1);
      end else begin
         qtr_ff <= qtr_ff - 6'h01;
      end
   end
   assign tick = (qtr_ff == '0);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tmr_ff <= '0;
      end else if (state_ff == ST_FREE || state_ff == ST_WAITSTOP || state_ff == ST_HOLD) begin
         tmr_ff <= tmr_ff + 1'b1;
      end else begin
         tmr_ff <= '0;
      end
   end
   assign tmo = (tmr_ff == TW'(TIMEOUT_CYC - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         free_ff <= '0;
      end else if (state_ff != ST_FREE || !scl_s || !sda_s) begin
         free_ff <= '0;
      end else if (free_ff != 8'(`FREE_CYC)) begin
         free_ff <= free_ff + 8'h01;
      end
   end

   assign go = (state_ff == ST_IDLE) && por_s && rstn_s;
   assign reg_byte = (off_ff >= `OFF_REG_LO) && (off_ff <= `OFF_REG_HI);
   assign lost = (state_ff == ST_TX) && bit_val && !sda_s;

   always_comb begin
      bit_val = 1'b1;
      if (state_ff == ST_TX) begin
         bit_val = sh_ff[7];
      end else if (state_ff == ST_RXACK) begin
         bit_val = (off_ff == `OFF_CRC) ? `NACK_BIT : `ACK_BIT;
      end
   end

   // ----------------------------------------
   // Main sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff    <= ST_IDLE;
         step_ff     <= TX_ADDR_W;
         ph_ff       <= `PH_SET;
         bit_ff      <= '0;
         sh_ff       <= '0;
         off_ff      <= '0;
         crc_ff      <= `CRC_INIT;
         fast_ff     <= 1'b0;
         bad_ff      <= 1'b0;
         retry_ff    <= '0;
         scl_oe_n_ff <= 1'b1;
         sda_oe_n_ff <= 1'b1;
      end else begin
         unique case (state_ff)
            ST_IDLE: if (go) begin
               state_ff <= memory_boot_skip_n_i ? ST_DONE : ST_FREE;
            end
            ST_FREE: if (tmo) begin
               state_ff <= ST_FAIL;
            end else if (free_ff == 8'(`FREE_CYC) && tick) begin
               state_ff <= ST_START;
               step_ff  <= TX_ADDR_W;
               sh_ff    <= tx_byte(TX_ADDR_W, memory_base_slave_address_i);
               ph_ff    <= `PH_SET;
               bit_ff   <= '0;
               off_ff   <= 8'(`OFF_START & 16'h00FF);
               crc_ff   <= `CRC_INIT;
               fast_ff  <= 1'b0;
               bad_ff   <= 1'b0;
            end
            ST_START: if (tick) begin
               ph_ff <= ph_ff + 2'h1;
               if (ph_ff == `PH_RISE) begin
                  sda_oe_n_ff <= 1'b0;
               end
               if (ph_ff == `PH_SAMPLE) begin
                  scl_oe_n_ff <= 1'b0;
               end
               if (ph_ff == `PH_FALL) begin
                  state_ff <= ST_TX;
               end
            end
            ST_RSTART: if (tick) begin
               ph_ff <= ph_ff + 2'h1;
               if (ph_ff == `PH_SET) begin
                  sda_oe_n_ff <= 1'b1;
               end
               if (ph_ff == `PH_RISE) begin
                  scl_oe_n_ff <= 1'b1;
               end
               if (ph_ff == `PH_SAMPLE) begin
                  sda_oe_n_ff <= 1'b0;
               end
               if (ph_ff == `PH_FALL) begin
                  scl_oe_n_ff <= 1'b0;
                  step_ff     <= TX_ADDR_R;
                  sh_ff       <= tx_byte(TX_ADDR_R, memory_base_slave_address_i);
                  state_ff    <= ST_TX;
               end
            end
            ST_TX, ST_TXACK, ST_RX, ST_RXACK: if (tick) begin
               ph_ff <= ph_ff + 2'h1;
               if (ph_ff == `PH_SET) begin
                  sda_oe_n_ff <= bit_val;
               end
               if (ph_ff == `PH_RISE) begin
                  scl_oe_n_ff <= 1'b1;
               end
               if (ph_ff == `PH_SAMPLE) begin
                  if (lost) begin
                     scl_oe_n_ff <= 1'b1;
                     sda_oe_n_ff <= 1'b1;
                     if (step_ff == TX_ADDR_W && retry_ff != arbitration_retry_count_i) begin
                        retry_ff <= retry_ff + 5'h01;
                        state_ff <= ST_WAITSTOP;
                     end else begin
                        state_ff <= ST_FAIL;
                     end
                  end
                  if (state_ff == ST_TXACK && sda_s) begin
                     bad_ff <= 1'b1;
                  end
                  if (state_ff == ST_RX) begin
                     sh_ff <= {sh_ff[6:0], sda_s};
                  end
               end
               if (ph_ff == `PH_FALL) begin
                  scl_oe_n_ff <= 1'b0;
                  unique case (state_ff)
                     ST_TX: if (bit_ff == `BIT_LAST) begin
                        bit_ff   <= '0;
                        state_ff <= ST_TXACK;
                     end else begin
                        bit_ff <= bit_ff + 3'h1;
                        sh_ff  <= {sh_ff[6:0], 1'b0};
                     end
                     ST_TXACK: if (bad_ff) begin
                        state_ff <= ST_STOP;
                     end else begin
                        unique case (step_ff)
                           TX_ADDR_W: begin
                              step_ff  <= wide_offset_select_i ? TX_OFF_HI : TX_OFF_LO;
                              sh_ff    <= tx_byte(wide_offset_select_i ? TX_OFF_HI : TX_OFF_LO,
                                                  memory_base_slave_address_i);
                              state_ff <= ST_TX;
                           end
                           TX_OFF_HI: begin
                              step_ff  <= TX_OFF_LO;
                              sh_ff    <= tx_byte(TX_OFF_LO, memory_base_slave_address_i);
                              state_ff <= ST_TX;
                           end
                           TX_OFF_LO: state_ff <= ST_RSTART;
                           TX_ADDR_R: state_ff <= ST_RX;
                        endcase
                     end
                     ST_RX: if (bit_ff == `BIT_LAST) begin
                        bit_ff   <= '0;
                        state_ff <= ST_HOLD;
                     end else begin
                        bit_ff <= bit_ff + 3'h1;
                     end
                     default: if (off_ff == `OFF_CRC) begin
                        state_ff <= ST_STOP;
                     end else begin
                        off_ff   <= off_ff + 8'h01;
                        state_ff <= ST_RX;
                     end
                  endcase
               end
            end
            ST_HOLD: if (tmo) begin
               scl_oe_n_ff <= 1'b1;
               sda_oe_n_ff <= 1'b1;
               state_ff    <= ST_FAIL;
            end else if (!reg_byte || push_s.ready) begin
               if (off_ff < `OFF_CRC) begin
                  crc_ff <= crc8(crc_ff, sh_ff);
               end
               if (off_ff == `OFF_SPEED) begin
                  fast_ff <= sh_ff[`SPEED_BIT];
               end
               if (off_ff == `OFF_CRC && sh_ff != crc_ff) begin
                  bad_ff <= 1'b1;
               end
               ph_ff    <= `PH_SET;
               state_ff <= ST_RXACK;
            end
            ST_STOP: if (tick) begin
               ph_ff <= ph_ff + 2'h1;
               if (ph_ff == `PH_SET) begin
                  sda_oe_n_ff <= 1'b0;
               end
               if (ph_ff == `PH_RISE) begin
                  scl_oe_n_ff <= 1'b1;
               end
               if (ph_ff == `PH_SAMPLE) begin
                  sda_oe_n_ff <= 1'b1;
               end
               if (ph_ff == `PH_FALL) begin
                  state_ff <= bad_ff ? ST_FAIL : ST_DONE;
               end
            end
            ST_WAITSTOP: if (tmo) begin
               state_ff <= ST_FAIL;
            end else if (stop_det) begin
               state_ff <= ST_FREE;
            end
            ST_DONE: state_ff <= ST_DONE;
            ST_FAIL: begin
               scl_oe_n_ff <= 1'b1;
               sda_oe_n_ff <= 1'b1;
            end
            default: state_ff <= ST_FAIL;
         endcase
      end
   end

   // ----------------------------------------
   // Register image stream
   // ----------------------------------------
   assign push_s.valid = (state_ff == ST_HOLD) && reg_byte && !tmo;
   assign push_s.data  = {off_ff, sh_ff};

   boot_fifo #(
      .WIDTH($bits(cfg_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .in_s  (push_s.snk),
      .out_s (pop_s.src)
   );

   logic       cfg_wr_ff;
   cfg_word_t  cfg_ff;
   assign pop_s.ready = !cfg_wr_ff || cfg_ready_i;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_wr_ff <= 1'b0;
         cfg_ff    <= '0;
      end else if (pop_s.ready) begin
         cfg_wr_ff <= pop_s.valid;
         cfg_ff    <= pop_s.data;
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   logic       busy_ff;
   logic       spe_ff;
   logic       done_ff;
   logic       fail_ff;
   logic [1:0] lol_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
         spe_ff  <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         lol_ff  <= 2'h0;
      end else begin
         busy_ff <= state_ff != ST_IDLE && state_ff != ST_DONE && state_ff != ST_FAIL;
         spe_ff  <= (state_ff == ST_DONE || state_ff == ST_FAIL) && !cfg_wr_ff;
         done_ff <= state_ff == ST_DONE;
         fail_ff <= state_ff == ST_FAIL;
         lol_ff  <= pll_lock_lost_i | {2{state_ff == ST_FAIL}};
      end
   end

   assign scl_o                    = 1'b0;
   assign sda_o                    = 1'b0;
   assign scl_oe_n_o               = scl_oe_n_ff;
   assign sda_oe_n_o               = sda_oe_n_ff;
   assign cfg_wr_o                 = cfg_wr_ff;
   assign cfg_addr_o               = cfg_ff.off;
   assign cfg_data_o               = cfg_ff.data;
   assign boot_busy_o              = busy_ff;
   assign serial_port_enable_o     = spe_ff;
   assign boot_done_o              = done_ff;
   assign boot_load_failed_flag_o  = fail_ff;
   assign pll_unlocked_indicator_o = lol_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   start_gate_a: assert property (go |=> state_ff != ST_IDLE) else $error("boot did not leave idle");
   skip_boot_a: assert property (go && memory_boot_skip_n_i |=> state_ff == ST_DONE)
      else $error("skip bit did not bypass memory");
   nack_abort_a: assert property (state_ff == ST_TXACK && tick && ph_ff == `PH_SAMPLE && sda_s
      |=> bad_ff) else $error("slave nack not recorded");
   stop_fail_a: assert property (state_ff == ST_STOP && tick && ph_ff == `PH_FALL && bad_ff
      |=> state_ff == ST_FAIL ##1 boot_load_failed_flag_o) else $error("abort did not raise fail flag");
   lol_force_a: assert property (boot_load_failed_flag_o |=> pll_unlocked_indicator_o == 2'h3)
      else $error("fail flag did not force lock indicators");
   port_quiet_a: assert property (boot_busy_o |-> !serial_port_enable_o)
      else $error("serial port enabled during boot");
   read_release_a: assert property (state_ff == ST_RX && ph_ff != `PH_SET |-> sda_oe_n_o)
      else $error("data line driven during read");
   retry_bound_a: assert property (retry_ff <= arbitration_retry_count_i)
      else $error("retry count exceeded");
   timeout_a: assert property (tmo && state_ff == ST_HOLD |=> state_ff == ST_FAIL)
      else $error("response timer did not abandon cycle");
   arb_release_a: assert property (state_ff == ST_WAITSTOP |-> scl_oe_n_o && sda_oe_n_o)
      else $error("bus not released after arbitration loss");

   done_c: cover property (state_ff == ST_STOP ##1 state_ff == ST_DONE);
   retry_c: cover property (state_ff == ST_WAITSTOP ##[1:1000] state_ff == ST_FREE);
   fast_c: cover property ($rose(fast_ff));
   crc_fail_c: cover property (state_ff == ST_HOLD && off_ff == `OFF_CRC && sh_ff != crc_ff);
endmodule

// ==== test/eeprom_model.sv ====
// Behavioural serial memory answering offset writes and sequential reads.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/1ns
module eeprom_model #(parameter logic [6:0] ADDR = 7'h50) (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_oe_n_o
);
   logic [7:0] mem [0:255];
   logic [7:0] sh;
   logic [7:0] ptr   = 8'h00;
   logic       rd    = 1'b0;
   logic       first = 1'b0;
   logic       act   = 1'b0;
   int         cnt   = 0;
   int         nwr   = 0;
   initial sda_oe_n_o = 1'b1;
   always @(negedge sda_i) if (scl_i) begin
      cnt = -1;
      first = 1'b1;
      act = 1'b1;
      rd = 1'b0;
   end
   always @(posedge sda_i) if (scl_i) act = 1'b0;
   always @(posedge scl_i) if (act) begin
      if (!rd) sh = {sh[6:0], sda_i};
      if (rd && cnt == 8 && sda_i) act = 1'b0;
   end
   always @(negedge scl_i) if (act) begin
      cnt = (cnt == 8) ? 0 : cnt + 1;
      sda_oe_n_o = 1'b1;
      if (cnt == 8 && !rd) begin
         if (first) begin
            act = (sh[7:1] == ADDR);
            rd = sh[0];
            first = 1'b0;
            if (!sh[0]) nwr = 0;
         end else begin
            ptr = sh;
            nwr = nwr + 1;
         end
         sda_oe_n_o = !act;
      end else if (rd && cnt < 8) sda_oe_n_o = mem[ptr][7 - cnt];
      else if (rd) ptr = ptr + 8'h01;
   end
endmodule

// ==== test/i2c_eeprom_boot_loader_tb_top.sv ====
// Bench that boots the loader against the memory model five times.
// Assumes the loader, FIFO, package and memory model are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module i2c_eeprom_boot_loader_tb_top;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       ext_rst_low = 1'b0;
   logic       por = 1'b0;
   logic       skip = 1'b0;
   logic       rdy = 1'b0;
   logic [6:0] base = 7'h50;
   logic [7:0] nidx = 8'h08;
   logic       wide = 1'b1;
   logic       rival = 1'b0;
   wire        scl_oe_n, sda_oe_n, eep_oe_n, cfg_wr, busy, spe, done, fail;
   wire  [7:0] cfg_addr, cfg_data;
   wire  [1:0] pll_ind;
   wire        scl = scl_oe_n;
   wire        sda = sda_oe_n & eep_oe_n & ~rival;
   int         err_total = 0;
   int         samples_checked = 0;
   always #20 clk_i = ~clk_i;
   function automatic logic [7:0] img(int i);
      return (i < 6) ? 8'hFF : (i == 6) ? 8'hD7 : (i == 7) ? 8'h00 : 8'(i) ^ 8'h3C;
   endfunction
   function automatic logic [7:0] crc();
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 224; i++) begin
         c ^= img(i);
         for (int b = 0; b < 8; b++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
      end
      return c;
   endfunction
   boot_loader #(.TIMEOUT_CYC(300)) i_boot_loader (
      .clk_i(clk_i), .rst_i(rst_i), .external_reset_low_i(ext_rst_low), .por_done_i(por),
      .memory_boot_skip_n_i(skip), .wide_offset_select_i(wide), .memory_base_slave_address_i(base),
      .arbitration_retry_count_i(5'h01), .pll_lock_lost_i(2'h1), .scl_i(scl), .sda_i(sda),
      .cfg_ready_i(rdy), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_o(), .sda_oe_n_o(sda_oe_n),
      .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data), .boot_busy_o(busy),
      .serial_port_enable_o(spe), .boot_done_o(done), .boot_load_failed_flag_o(fail),
      .pll_unlocked_indicator_o(pll_ind));
   eeprom_model #(.ADDR(7'h50)) i_eeprom_model (.scl_i(scl), .sda_i(sda), .sda_oe_n_o(eep_oe_n));
   initial for (int i = 0; i < 256; i++) i_eeprom_model.mem[i] = (i == 224) ? crc() : img(i);
   always @(posedge clk_i) #1 rdy <= ~rdy;
   always @(negedge clk_i) if (cfg_wr === 1'b1 && rdy === 1'b1) begin
      `CHK("cfg_addr", nidx, cfg_addr)
      `CHK("cfg_data", img(nidx), cfg_data)
      `CHK("port_off", 1'b0, spe)
      nidx <= nidx + 8'h01;
   end
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Mode 0 runs to the end, 1 resets in mid-read, 2 loses arbitration twice.
   task automatic boot(input logic s, input logic [6:0] b, input logic w, input int mode);
      rst_i = 1'b1;
      ext_rst_low = 1'b0;
      por = 1'b0;
      skip = s;
      base = b;
      wide = w;
      nidx <= 8'h08;
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      por = 1'b1;
      repeat (200) @(posedge clk_i);
      #1 `CHK("held_off", 1'b0, busy)
      ext_rst_low = 1'b1;
      if (mode == 1) begin
         wait (i_eeprom_model.rd === 1'b1 && i_eeprom_model.cnt == 2);
         @(posedge clk_i);
         #1 `CHK("cut_busy", 1'b1, busy)
         `CHK("one_offset", 1, i_eeprom_model.nwr)
         rst_i = 1'b1;
         @(posedge clk_i);
         #1 rst_i = 1'b0;
         repeat (2) begin
            @(posedge clk_i);
            #1 `CHK("cut_idle", 1'b0, busy)
            `CHK("cut_scl", 1'b1, scl_oe_n)
            `CHK("cut_sda", 1'b1, sda_oe_n)
         end
      end else begin
         repeat (mode) begin
            wait (scl_oe_n === 1'b0);
            @(posedge clk_i);
            #1 rival = 1'b1;
            repeat (300) @(posedge clk_i);
            #1 `CHK("arb_free", 1'b1, scl_oe_n)
            rival = 1'b0;
         end
         for (int k = 0; k < 150000 && done !== 1'b1 && fail !== 1'b1; k++) @(posedge clk_i);
         repeat (10) @(posedge clk_i);
         #1;
      end
   endtask
   initial begin
      boot(1'b1, 7'h50, 1'b1, 0);
      `CHK("skip_done", 1'b1, done)
      `CHK("skip_bus", 1'b1, sda_oe_n)
      boot(1'b0, 7'h51, 1'b1, 0);
      `CHK("nack_fail", 1'b1, fail)
      `CHK("nack_lol", 2'h3, pll_ind)
      `CHK("nack_none", 8'h08, nidx)
      boot(1'b0, 7'h50, 1'b1, 2);
      `CHK("arb_fail", 1'b1, fail)
      `CHK("arb_done", 1'b0, done)
      boot(1'b0, 7'h50, 1'b0, 1);
      boot(1'b0, 7'h50, 1'b1, 0);
      `CHK("crc_ok", 1'b0, fail)
      `CHK("load_done", 1'b1, done)
      `CHK("reg_count", 8'hE0, nidx)
      `CHK("two_offsets", 2, i_eeprom_model.nwr)
      `CHK("lol_pass", 2'h1, pll_ind)
      `CHK("port_on", 1'b1, spe)
      close_out();
   end
   initial begin
      #10000000;
      err_total++;
      close_out();
   end
endmodule
